// ===== logic/timer2_consts.svh
// constants for the dual-width auto-reload timer: register indices, field
// positions, reset values and divider counts.
// assumes: included by bare name; byte address is four times the index.
`ifndef TIMER2_CONSTS_SVH
`define TIMER2_CONSTS_SVH

// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_CLK_CTRL    8'h8e
`define IDX_CTRL        8'hc8
`define IDX_RELOAD_LOW  8'hca
`define IDX_RELOAD_HIGH 8'hcb
`define IDX_COUNT_LOW   8'hcc
`define IDX_COUNT_HIGH  8'hcd
`define IDX_CAPT_LOW    8'hd0
`define IDX_CAPT_HIGH   8'hd1
`define IDX_IRQ_STATUS  8'hd4
`define IDX_IRQ_CLEAR   8'hd5
`define IDX_IRQ_ENABLE  8'hd6

// ----------------------------------------
// field positions
// ----------------------------------------
`define CTRL_HIGH_FLAG  7
`define CTRL_LOW_FLAG   6
`define CTRL_LOW_INT_EN 5
`define CTRL_CAPT_EN    4
`define CTRL_SPLIT      3
`define CTRL_RUN        2
`define CLK_LOW_PICK    0
`define CLK_HIGH_PICK   1
`define IRQ_LOW_OVF     0
`define IRQ_HIGH_OVF    1
`define IRQ_CAPT        2

// ----------------------------------------
// reset values and divider counts
// ----------------------------------------
`define BYTE_RESET      8'h00
`define IRQ_RESET       3'h0
`define DIV12_LAST      4'hb
`define RTC_DIV8_LAST   3'h7

`endif

// ===== logic/timer2_pkg.sv
// types shared by the timer files.
// assumes: compiled before every module that imports it.
package timer2_pkg;
	typedef logic [7:0] byte_t;

	// external source / capture trigger pairing
	typedef enum logic [1:0] {
		SRC_DIV12_CAPT_RTC = 2'b00,
		SRC_CMP_CAPT_RTC   = 2'b01,
		SRC_DIV12_CAPT_CMP = 2'b10,
		SRC_RTC_CAPT_CMP   = 2'b11
	} src_sel_t;

	typedef enum logic {
		BUS_IDLE   = 1'b0,
		BUS_ANSWER = 1'b1
	} bus_state_t;
endpackage : timer2_pkg

// ===== logic/edge_sync.sv
// two-flop synchroniser with rising-edge pulse.
// assumes: one clock, synchronous active-high reset.
module edge_sync (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic async_in,
	output logic      rise
);
	import timer2_pkg::*;
	logic meta;
	logic stable;
	logic last;

	// ----------------------------------------
	// synchroniser chain
	// ----------------------------------------
	// meta is read by stable only
	always_ff @(posedge core_clk) begin
		if (srst) begin
			meta   <= 1'b0;
			stable <= 1'b0;
			last   <= 1'b0;
		end else begin
			meta   <= async_in;
			stable <= meta;
			last   <= stable;
		end
	end

	assign rise = stable & ~last;
endmodule : edge_sync

// ===== logic/byte_counter.sv
// one 8-bit counter byte with software load and reload on wrap.
// assumes: inc is a one-cycle tick already gated by run state.
module byte_counter (
	input  wire logic         core_clk,
	input  wire logic         srst,
	input  wire logic         inc,
	input  wire logic         reload_ok,
	input  timer2_pkg::byte_t reload_val,
	input  wire logic         sw_write,
	input  timer2_pkg::byte_t sw_val,
	output timer2_pkg::byte_t count,
	output logic              wrap
);
	import timer2_pkg::*;
	`include "timer2_consts.svh"
	byte_t next_count;

	// software write beats a tick in the same cycle
	always_comb begin
		wrap       = inc && !sw_write && (count == 8'hff);
		next_count = count;
		if (sw_write) begin
			next_count = sw_val;
		end else if (inc) begin
			next_count = (wrap && reload_ok) ? reload_val : count + 8'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			count <= `BYTE_RESET;
		end else begin
			count <= next_count;
		end
	end
endmodule : byte_counter

// ===== logic/timer2_top.sv
// auto-reload timer, one 16-bit or two 8-bit counters, avalon-mm slave.
// assumes: single core_clk, synchronous srst, one-wait-state bus master.
//
// Summary of operation
// RULE1: with split mode on the timer is two 8-bit counters, each reloading on overflow.
// RULE2: with split mode off the timer is one 16-bit counter reloading on overflow.
// RULE3: 16-bit counting needs the run bit; clearing it stops the 16-bit counter.
// RULE4: in split mode the run bit gates only the high byte; the low byte always counts.
// RULE5: select 00 counts system clock/12 and 01 comparator 0, both capturing on rtc/8.
// RULE6: select 10 counts system clock/12 and 11 rtc/8, both capturing on comparator 0.
// RULE7: in split mode both bytes share the one selected external source.
// RULE8: a per-byte pick bit chooses the external source or the system clock.
// RULE9: external sources and capture triggers are synchronised before use.
// RULE10: the low count register holds count bits 7:0, or the low split counter.
// RULE11: the high count register holds the upper byte, or the high split counter.
// RULE12: with capture enabled the count is latched on each capture trigger edge.
// RULE13: the high flag sets when the high byte or whole count wraps, never self-clears.
// RULE14: the low flag sets on every low byte wrap and only software clears it.
// RULE15: an overflowing counter loads its reload value and counts on from it.
// RULE16: an enabled counter steps by one per tick; ticks while disabled are lost.
//
// Local design decision: register access over Avalon-MM.
module timer2_top (
	input  wire logic        core_clk,
	input  wire logic        srst,
	input  wire logic [9:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        cmp0_in,
	input  wire logic        rtc_osc_in,
	output logic             irq
);
	import timer2_pkg::*;
	`include "timer2_consts.svh"

	// ----------------------------------------
	// state
	// ----------------------------------------
	bus_state_t  state;
	bus_state_t  next_state;
	logic [31:0] next_readdata;
	logic        next_waitrequest;
	logic [5:0]  ctrl;             // low int en, capt en, split, run, select
	logic [5:0]  next_ctrl;
	logic        high_flag;
	logic        next_high_flag;
	logic        low_flag;
	logic        next_low_flag;
	logic [1:0]  clk_ctrl;
	logic [1:0]  next_clk_ctrl;
	byte_t       reload_low;
	byte_t       next_reload_low;
	byte_t       reload_high;
	byte_t       next_reload_high;
	byte_t       capt_low;
	byte_t       next_capt_low;
	byte_t       capt_high;
	byte_t       next_capt_high;
	logic [2:0]  irq_status;
	logic [2:0]  next_irq_status;
	logic [2:0]  irq_enable;
	logic [2:0]  next_irq_enable;
	logic        next_irq;
	logic [3:0]  div12;
	logic [3:0]  next_div12;
	logic [2:0]  rtc_cnt;
	logic [2:0]  next_rtc_cnt;

	// ----------------------------------------
	// combinational nets
	// ----------------------------------------
	logic [7:0]  idx;
	logic        wr_hit;
	logic [31:0] rd_word;
	logic        split;
	logic        run;
	logic        capt_en;
	src_sel_t    src;
	logic        div_tick;
	logic        cmp_tick;
	logic        rtc_rise;
	logic        rtc_tick;
	logic        ext_tick;
	logic        cap_trig;
	logic        low_tick;
	logic        high_tick;
	logic        low_inc;
	logic        high_inc;
	logic        low_wrap;
	logic        high_wrap;
	byte_t       count_low;
	byte_t       count_high;
	logic        wr_low;
	logic        wr_high;
	logic        capt_evt;

	assign idx     = avs_address[9:2];
	assign wr_hit  = (state == BUS_ANSWER) && avs_write && avs_byteenable[0];
	assign wr_low  = wr_hit && (idx == `IDX_COUNT_LOW);
	assign wr_high = wr_hit && (idx == `IDX_COUNT_HIGH);
	assign split   = ctrl[`CTRL_SPLIT];
	assign run     = ctrl[`CTRL_RUN];
	assign capt_en = ctrl[`CTRL_CAPT_EN];
	assign src     = src_sel_t'(ctrl[1:0]);

	// ----------------------------------------
	// source conditioning
	// ----------------------------------------
	edge_sync u_cmp_sync ( // RULE9
		.core_clk (core_clk),
		.srst     (srst),
		.async_in (cmp0_in),
		.rise     (cmp_tick)
	);

	edge_sync u_rtc_sync ( // RULE9
		.core_clk (core_clk),
		.srst     (srst),
		.async_in (rtc_osc_in),
		.rise     (rtc_rise)
	);

	// system clock/12 and rtc/8 dividers
	always_comb begin
		div_tick     = (div12 == `DIV12_LAST);
		next_div12   = div_tick ? 4'h0 : div12 + 4'h1;
		rtc_tick     = rtc_rise && (rtc_cnt == `RTC_DIV8_LAST);
		next_rtc_cnt = rtc_rise ? rtc_cnt + 3'h1 : rtc_cnt;
	end

	// source and trigger selection
	always_comb begin
		case (src)
			SRC_DIV12_CAPT_RTC: begin // RULE5
				ext_tick = div_tick;
				cap_trig = rtc_tick;
			end
			SRC_CMP_CAPT_RTC: begin // RULE5
				ext_tick = cmp_tick;
				cap_trig = rtc_tick;
			end
			SRC_DIV12_CAPT_CMP: begin // RULE6
				ext_tick = div_tick;
				cap_trig = cmp_tick;
			end
			SRC_RTC_CAPT_CMP: begin // RULE6
				ext_tick = rtc_tick;
				cap_trig = cmp_tick;
			end
			default: begin
				ext_tick = 1'b0;
				cap_trig = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// counter bytes
	// ----------------------------------------
	// one shared external tick, system clock if picked
	always_comb begin
		low_tick  = clk_ctrl[`CLK_LOW_PICK] | ext_tick;  // RULE7 RULE8
		high_tick = clk_ctrl[`CLK_HIGH_PICK] | ext_tick; // RULE7 RULE8
		if (split) begin
			low_inc  = low_tick;         // RULE1 RULE4
			high_inc = run && high_tick; // RULE4 RULE16
		end else begin
			low_inc  = run && low_tick;  // RULE2 RULE3 RULE16
			high_inc = low_wrap;         // RULE2
		end
	end

	byte_counter u_low ( // RULE10 RULE15
		.core_clk   (core_clk),
		.srst       (srst),
		.inc        (low_inc),
		.reload_ok  (split || (count_high == 8'hff)),
		.reload_val (reload_low),
		.sw_write   (wr_low),
		.sw_val     (avs_writedata[7:0]),
		.count      (count_low),
		.wrap       (low_wrap)
	);

	byte_counter u_high ( // RULE11 RULE15
		.core_clk   (core_clk),
		.srst       (srst),
		.inc        (high_inc),
		.reload_ok  (1'b1),
		.reload_val (reload_high),
		.sw_write   (wr_high),
		.sw_val     (avs_writedata[7:0]),
		.count      (count_high),
		.wrap       (high_wrap)
	);

	// ----------------------------------------
	// registers, flags, capture, interrupt
	// ----------------------------------------
	always_comb begin
		capt_evt         = capt_en && cap_trig; // RULE12
		next_ctrl        = ctrl;
		next_clk_ctrl    = clk_ctrl;
		next_reload_low  = reload_low;
		next_reload_high = reload_high;
		next_irq_enable  = irq_enable;
		next_high_flag   = high_flag;
		next_low_flag    = low_flag;
		next_capt_low    = capt_en && cap_trig ? count_low : capt_low;   // RULE12
		next_capt_high   = capt_en && cap_trig ? count_high : capt_high; // RULE12
		next_irq_status  = irq_status;
		if (wr_hit) begin
			case (idx)
				`IDX_CTRL: begin
					next_ctrl      = avs_writedata[5:0];
					next_high_flag = avs_writedata[`CTRL_HIGH_FLAG];
					next_low_flag  = avs_writedata[`CTRL_LOW_FLAG];
				end
				`IDX_CLK_CTRL:    next_clk_ctrl    = avs_writedata[1:0];
				`IDX_RELOAD_LOW:  next_reload_low  = avs_writedata[7:0];
				`IDX_RELOAD_HIGH: next_reload_high = avs_writedata[7:0];
				`IDX_IRQ_ENABLE:  next_irq_enable  = avs_writedata[2:0];
				`IDX_IRQ_CLEAR:   next_irq_status  = irq_status & ~avs_writedata[2:0];
				default: begin
				end
			endcase
		end
		// hardware set wins over software clear
		if (high_wrap) begin
			next_high_flag = 1'b1; // RULE13
		end
		if (low_wrap) begin
			next_low_flag = 1'b1; // RULE14
		end
		next_irq_status = next_irq_status | {capt_evt, high_wrap, low_wrap};
		next_irq        = |(next_irq_status & next_irq_enable);
	end

	// ----------------------------------------
	// avalon-mm slave, one wait state
	// ----------------------------------------
	always_comb begin
		case (idx)
			`IDX_CTRL:        rd_word = {24'h0, high_flag, low_flag, ctrl};
			`IDX_CLK_CTRL:    rd_word = {30'h0, clk_ctrl};
			`IDX_RELOAD_LOW:  rd_word = {24'h0, reload_low};
			`IDX_RELOAD_HIGH: rd_word = {24'h0, reload_high};
			`IDX_COUNT_LOW:   rd_word = {24'h0, count_low};  // RULE10
			`IDX_COUNT_HIGH:  rd_word = {24'h0, count_high}; // RULE11
			`IDX_CAPT_LOW:    rd_word = {24'h0, capt_low};
			`IDX_CAPT_HIGH:   rd_word = {24'h0, capt_high};
			`IDX_IRQ_STATUS:  rd_word = {29'h0, irq_status};
			`IDX_IRQ_ENABLE:  rd_word = {29'h0, irq_enable};
			default:          rd_word = 32'h0;
		endcase
		next_readdata = avs_readdata;
		next_state    = BUS_IDLE;
		if (state == BUS_IDLE && (avs_read || avs_write)) begin
			next_state = BUS_ANSWER;
			if (avs_read) begin
				next_readdata = rd_word;
			end
		end
		next_waitrequest = (next_state != BUS_ANSWER);
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			state           <= BUS_IDLE;
			avs_readdata    <= 32'h0;
			avs_waitrequest <= 1'b1;
			ctrl            <= 6'h00;
			high_flag       <= 1'b0;
			low_flag        <= 1'b0;
			clk_ctrl        <= 2'h0;
			reload_low      <= `BYTE_RESET;
			reload_high     <= `BYTE_RESET;
			capt_low        <= `BYTE_RESET;
			capt_high       <= `BYTE_RESET;
			irq_status      <= `IRQ_RESET;
			irq_enable      <= `IRQ_RESET;
			irq             <= 1'b0;
			div12           <= 4'h0;
			rtc_cnt         <= 3'h0;
		end else begin
			state           <= next_state;
			avs_readdata    <= next_readdata;
			avs_waitrequest <= next_waitrequest;
			ctrl            <= next_ctrl;
			high_flag       <= next_high_flag;
			low_flag        <= next_low_flag;
			clk_ctrl        <= next_clk_ctrl;
			reload_low      <= next_reload_low;
			reload_high     <= next_reload_high;
			capt_low        <= next_capt_low;
			capt_high       <= next_capt_high;
			irq_status      <= next_irq_status;
			irq_enable      <= next_irq_enable;
			irq             <= next_irq;
			div12           <= next_div12;
			rtc_cnt         <= next_rtc_cnt;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	a_split_low_reload: assert property ( // RULE1
		split && low_inc && !wr_low && count_low == 8'hff |=> count_low == $past(reload_low)
	) else $error("split low byte did not reload");
	a_full_reload: assert property ( // RULE2
		!split && low_inc && count_low == 8'hff && count_high == 8'hff && !wr_low && !wr_high
		|=> count_low == $past(reload_low) && count_high == $past(reload_high)
	) else $error("16-bit count did not reload");
	a_stop_holds: assert property ( // RULE3
		!split && !run && !wr_low && !wr_high |=> $stable(count_low) && $stable(count_high)
	) else $error("stopped 16-bit count moved");
	a_split_high_gate: assert property ( // RULE4
		split && !run && !wr_high |=> $stable(count_high)
	) else $error("split high byte moved while stopped");
	a_src_low_sel: assert property ( // RULE5
		src == SRC_CMP_CAPT_RTC |-> ext_tick == cmp_tick && cap_trig == rtc_tick
	) else $error("select 01 source mismatch");
	a_div12_period: assert property ( // RULE5
		div_tick |-> ##12 div_tick
	) else $error("system clock/12 tick period wrong");
	a_src_high_sel: assert property ( // RULE6
		src == SRC_RTC_CAPT_CMP |-> ext_tick == rtc_tick && cap_trig == cmp_tick
	) else $error("select 11 source mismatch");
	a_split_shared: assert property ( // RULE7
		split && run && ext_tick |-> low_inc && high_inc
	) else $error("split bytes do not share the tick");
	a_low_pick_step: assert property ( // RULE8 RULE16
		split && clk_ctrl[`CLK_LOW_PICK] && !wr_low && count_low != 8'hff
		|=> count_low == $past(count_low) + 8'h01
	) else $error("picked low byte did not step by one");
	a_cmp_synced: assert property ( // RULE9
		cmp_tick |-> $past(cmp0_in, 2) && !$past(cmp0_in, 3)
	) else $error("comparator edge not delayed by sync");
	a_read_low: assert property ( // RULE10
		state == BUS_IDLE && avs_read && idx == `IDX_COUNT_LOW
		|=> avs_readdata[7:0] == $past(count_low)
	) else $error("low count readback wrong");
	a_read_high: assert property ( // RULE11
		state == BUS_IDLE && avs_read && idx == `IDX_COUNT_HIGH
		|=> avs_readdata == {24'h0, $past(count_high)}
	) else $error("high count readback wrong");
	a_capture_latch: assert property ( // RULE12
		capt_en && cap_trig |=> {capt_high, capt_low} == $past({count_high, count_low})
	) else $error("capture did not latch the count");
	a_high_flag_set: assert property ( // RULE13
		high_wrap |=> high_flag ##0 irq_status[`IRQ_HIGH_OVF]
	) else $error("high overflow flag not set");
	a_low_flag_set: assert property ( // RULE14
		low_wrap |=> low_flag && irq_status[`IRQ_LOW_OVF]
	) else $error("low overflow flag not set");
	a_bus_answer: assert property (
		state == BUS_IDLE && (avs_read || avs_write) |=> !avs_waitrequest ##1 avs_waitrequest
	) else $error("bus answer not one wait state");
endmodule : timer2_top

// ===== tb/timer2_mode_clock_counter_bench.sv
// self-checking bench for the dual-width auto-reload timer.
// assumes: timer2_top with a one-wait-state avalon slave, constants header,
// bench drives all ports itself, no partner model.
`include "timer2_consts.svh"
module timer2_mode_clock_counter_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import timer2_pkg::*;

	logic        core_clk        = 1'b0;
	logic        srst            = 1'b1;
	logic [9:0]  avs_address     = 10'h000;
	logic        avs_read        = 1'b0;
	logic        avs_write       = 1'b0;
	logic [31:0] avs_writedata   = 32'h0;
	logic [3:0]  avs_byteenable  = 4'h1;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        cmp0_in         = 1'b0;
	logic        rtc_osc_in      = 1'b0;
	logic        irq;
	int          error_cnt       = 0;
	int          n_tests         = 0;
	int          cycles          = 0;

	timer2_top dut (
		.core_clk        (core_clk),
		.srst            (srst),
		.avs_address     (avs_address),
		.avs_read        (avs_read),
		.avs_write       (avs_write),
		.avs_writedata   (avs_writedata),
		.avs_byteenable  (avs_byteenable),
		.avs_readdata    (avs_readdata),
		.avs_waitrequest (avs_waitrequest),
		.cmp0_in         (cmp0_in),
		.rtc_osc_in      (rtc_osc_in),
		.irq             (irq)
	);

	// 200 mhz core clock
	initial begin
		forever #2.5 core_clk = ~core_clk;
	end

	// hang guard, far above the expected run length
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			error_cnt++;
			conclude();
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic conclude();
		if (error_cnt == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic chk_in(input logic [31:0] v, input logic [31:0] lo, input logic [31:0] hi);
		check({31'h0, (v >= lo) && (v <= hi)}, 32'h1);
	endtask : chk_in

	// one avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic w, input byte_t idx, input logic [31:0] wd,
		output logic [31:0] rdat);
		int n;
		n = 0;
		@(posedge core_clk);
		avs_address   <= {idx, 2'b00};
		avs_writedata <= wd;
		avs_write     <= w;
		avs_read      <= ~w;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0);
		rdat = avs_readdata;
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		// slave answers after exactly one wait state
		check(n, 32'h2);
	endtask : bus

	task automatic wr(input byte_t idx, input logic [31:0] wd);
		logic [31:0] dummy;
		bus(1'b1, idx, wd, dummy);
	endtask : wr

	task automatic rd(input byte_t idx, output logic [31:0] r);
		bus(1'b0, idx, 32'h0, r);
	endtask : rd

	task automatic rd_chk(input byte_t idx, input logic [31:0] exp);
		logic [31:0] r;
		rd(idx, r);
		check(r, exp);
	endtask : rd_chk

	// n pulses, 8 cycles each, on the comparator and/or rtc inputs
	task automatic wiggle(input int n, input logic do_cmp, input logic do_rtc);
		repeat (n) begin
			@(posedge core_clk);
			cmp0_in    <= do_cmp;
			rtc_osc_in <= do_rtc;
			repeat (4) @(posedge core_clk);
			cmp0_in    <= 1'b0;
			rtc_osc_in <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
	endtask : wiggle

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset();
		byte_t idx[11];
		idx = '{`IDX_CLK_CTRL, `IDX_CTRL, `IDX_RELOAD_LOW, `IDX_RELOAD_HIGH,
			`IDX_COUNT_LOW, `IDX_COUNT_HIGH, `IDX_CAPT_LOW, `IDX_CAPT_HIGH,
			`IDX_IRQ_STATUS, `IDX_IRQ_ENABLE, 8'h00};
		foreach (idx[i]) begin
			rd_chk(idx[i], 32'h0);
		end
	endtask : t_reset

	// 16-bit mode on system clock: carry without reload, then full wrap with reload
	// flags are read while running, since a control write of 0 clears them
	task automatic t_wide();
		logic [31:0] a;
		wr(`IDX_CLK_CTRL, 32'h1);
		wr(`IDX_RELOAD_LOW, 32'h34);
		wr(`IDX_RELOAD_HIGH, 32'h12);
		wr(`IDX_COUNT_LOW, 32'hf0);
		wr(`IDX_COUNT_HIGH, 32'h00);
		wr(`IDX_CTRL, 32'h04);
		repeat (20) @(posedge core_clk);
		rd_chk(`IDX_CTRL, 32'h44);
		wr(`IDX_CTRL, 32'h00);
		rd_chk(`IDX_COUNT_HIGH, 32'h01);
		rd(`IDX_COUNT_LOW, a);
		chk_in(a, 32'h02, 32'h0c);
		repeat (10) @(posedge core_clk);
		rd_chk(`IDX_COUNT_LOW, a);
		wr(`IDX_COUNT_LOW, 32'hf0);
		wr(`IDX_COUNT_HIGH, 32'hff);
		wr(`IDX_CTRL, 32'h04);
		repeat (20) @(posedge core_clk);
		rd_chk(`IDX_CTRL, 32'hc4);
		wr(`IDX_CTRL, 32'h00);
		rd_chk(`IDX_COUNT_HIGH, 32'h12);
		rd(`IDX_COUNT_LOW, a);
		chk_in(a, 32'h34, 32'h42);
		rd_chk(`IDX_CTRL, 32'h00);
	endtask : t_wide

	// split mode: low runs without the run bit, each byte reloads on its own
	task automatic t_split();
		logic [31:0] a;
		wr(`IDX_CLK_CTRL, 32'h3);
		wr(`IDX_RELOAD_LOW, 32'h80);
		wr(`IDX_RELOAD_HIGH, 32'h10);
		wr(`IDX_COUNT_HIGH, 32'hfc);
		wr(`IDX_COUNT_LOW, 32'hf0);
		wr(`IDX_CTRL, 32'h08);
		repeat (20) @(posedge core_clk);
		rd(`IDX_COUNT_LOW, a);
		chk_in(a, 32'h80, 32'h8c);
		rd_chk(`IDX_COUNT_HIGH, 32'hfc);
		rd_chk(`IDX_CTRL, 32'h48);
		wr(`IDX_CTRL, 32'h0c);
		repeat (20) @(posedge core_clk);
		rd_chk(`IDX_CTRL, 32'h8c);
		wr(`IDX_CTRL, 32'h08);
		rd(`IDX_COUNT_HIGH, a);
		chk_in(a, 32'h16, 32'h2c);
		wr(`IDX_CTRL, 32'h00);
	endtask : t_split

	// every source select, split sharing and per-byte pick
	task automatic t_sources();
		logic [31:0] a;
		logic [7:0] clk[6] = '{8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h2};
		logic [7:0] ctl[6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0d, 8'h0d};
		logic [7:0] llo[6] = '{8'h09, 8'h08, 8'h09, 8'h02, 8'h0a, 8'h0a};
		logic [7:0] lhi[6] = '{8'h0c, 8'h08, 8'h0c, 8'h02, 8'h0a, 8'h0a};
		logic [7:0] hlo[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h78};
		logic [7:0] hhi[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h90};
		for (int i = 0; i < 6; i++) begin
			wr(`IDX_CLK_CTRL, {24'h0, clk[i]});
			wr(`IDX_COUNT_LOW, 32'h0);
			wr(`IDX_COUNT_HIGH, 32'h0);
			wr(`IDX_CTRL, {24'h0, ctl[i]});
			wiggle(8, 1'b1, 1'b1);
			wiggle(8, 1'b0, 1'b1);
			wr(`IDX_CTRL, {24'h0, ctl[i] & 8'hfb});
			wiggle(2, 1'b1, 1'b1);
			rd(`IDX_COUNT_LOW, a);
			chk_in(a, {24'h0, llo[i]}, {24'h0, lhi[i]});
			rd(`IDX_COUNT_HIGH, a);
			chk_in(a, {24'h0, hlo[i]}, {24'h0, hhi[i]});
		end
		wr(`IDX_CTRL, 32'h00);
	endtask : t_sources

	// capture triggers, interrupt mask and clear, ignored writes
	task automatic t_capture();
		logic [31:0] cap;
		logic [31:0] cnt;
		wr(`IDX_CLK_CTRL, 32'h1);
		wr(`IDX_COUNT_LOW, 32'h0);
		wr(`IDX_COUNT_HIGH, 32'h0);
		wr(`IDX_IRQ_CLEAR, 32'h7);
		wr(`IDX_CTRL, 32'h14);
		wiggle(1, 1'b1, 1'b0);
		rd_chk(`IDX_IRQ_STATUS, 32'h0);
		wiggle(8, 1'b0, 1'b1);
		rd_chk(`IDX_IRQ_STATUS, 32'h4);
		check({31'h0, irq}, 32'h0);
		wr(`IDX_IRQ_ENABLE, 32'h4);
		repeat (2) @(posedge core_clk);
		check({31'h0, irq}, 32'h1);
		wr(`IDX_IRQ_CLEAR, 32'h4);
		repeat (2) @(posedge core_clk);
		check({31'h0, irq}, 32'h0);
		wr(`IDX_IRQ_STATUS, 32'h7);
		rd_chk(`IDX_IRQ_STATUS, 32'h0);
		wr(`IDX_CTRL, 32'h16);
		wiggle(1, 1'b1, 1'b0);
		wr(`IDX_CTRL, 32'h12);
		rd(`IDX_CAPT_LOW, cap);
		rd(`IDX_COUNT_LOW, cnt);
		chk_in(cap, 32'h1, cnt - 32'h1);
		rd_chk(`IDX_IRQ_STATUS, 32'h4);
		@(posedge core_clk);
		avs_byteenable <= 4'h0;
		wr(`IDX_COUNT_LOW, 32'h5a);
		avs_byteenable <= 4'h1;
		rd_chk(`IDX_COUNT_LOW, cnt);
		wr(`IDX_COUNT_HIGH, 32'ha5);
		rd_chk(`IDX_COUNT_HIGH, 32'ha5);
	endtask : t_capture

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		t_reset();
		t_wide();
		t_split();
		t_sources();
		t_capture();
		conclude();
	end
endmodule : timer2_mode_clock_counter_bench
